// [rtl/nnsf_status.sv]
// status word, latched event flags and interrupt request of a network node
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps

// Contract
// - status word is 16 bits, 13 meaningful, bits 15:13 read zero
// - bit 0 latches setting change error and may raise the interrupt
// - bit 1 latches port data write error and may raise the interrupt
// - bit 2 latches port write processing error and may raise the interrupt
// - bit 3 latches monitored port change, or enabled falling/rising edge watch
// - bit 4 latches broadcast reception only while its enable is set
// - bit 5 latches relative time counter overflow when its enable is set
// - bit 6 latches change information loss when its enable is set
// - bit 7 latches network communication timeout when its enable is set
// - bit 8 shows connection, changed only by operation commands
// - bit 9 shows break monitoring, cleared once a break request is answered
// - bit 10 mirrors watchdog pin: one while pin low after expiry
// - bit 11 reads one while a port data memory write runs
// - bit 12 latches virtual count error and never raises the interrupt
// - any latched flag in bits 0 to 7 may drive the interrupt output
// - codes 20h to 26h clear bits 0,1,2,4,5,6,7 in order
// - code 10h connects and sets bit 8; 11h disconnects and clears it
// - code 12h enables break answering and sets bit 9
module nnsf_status
    import nnsf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [NNSF_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [NNSF_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [NNSF_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire nnsf_events_t core_events,
    input wire logic break_request_answered,
    input wire logic watchdog_pin_low,
    input wire logic port_write_in_progress,
    output logic network_connected,
    output logic break_monitoring,
    output logic irq
);

    // ****************************************
    // bus slave handshake
    // ****************************************

    nnsf_bus_state_t bus_q;
    nnsf_bus_state_t bus_d;
    logic req;
    logic wr_go;
    logic [15:0] status_word;
    logic [NNSF_DATA_W-1:0] rd_value;

    assign req = avs_read | avs_write;

    // one wait cycle, then a single answer cycle
    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            NNSF_BUS_IDLE: begin
                if (req) begin
                    bus_d = NNSF_BUS_ACK;
                end
            end
            NNSF_BUS_ACK: begin
                bus_d = NNSF_BUS_IDLE;
            end
            default: begin
                bus_d = NNSF_BUS_IDLE;
            end
        endcase
    end

    // handshake state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= NNSF_BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    assign avs_waitrequest = (bus_q != NNSF_BUS_ACK);
    assign wr_go = avs_write & (bus_q == NNSF_BUS_ACK);

    // ****************************************
    // software visible registers
    // ****************************************

    logic [5:0] env_q;
    logic [8:0] mask_q;
    logic cmd_hit;
    logic [7:0] opcode;
    logic status_w1c_lo;
    logic status_w1c_hi;

    assign opcode = avs_writedata[7:0];
    assign cmd_hit = wr_go & (avs_address == NNSF_OFS_CMD) & avs_byteenable[0];
    assign status_w1c_lo = wr_go & (avs_address == NNSF_OFS_STATUS) & avs_byteenable[0];
    assign status_w1c_hi = wr_go & (avs_address == NNSF_OFS_STATUS) & avs_byteenable[1];

    // environment enables steer event qualification
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            env_q <= NNSF_ENV_RST;
        end else if (wr_go && avs_address == NNSF_OFS_ENV && avs_byteenable[0]) begin
            env_q <= avs_writedata[5:0];
        end
    end

    // mask: bits 7:0 gate flags, bit 8 is stored and read back at bit 12 but gates nothing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= NNSF_MASK_RST;
        end else if (wr_go && avs_address == NNSF_OFS_MASK) begin
            if (avs_byteenable[0]) begin
                mask_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                mask_q[8] <= avs_writedata[NNSF_B_VCOUNT_ERR];
            end
        end
    end

    // ****************************************
    // event flags
    // ****************************************

    logic [7:0] flags_q;
    logic [7:0] flags_set;
    logic [7:0] flags_clr;
    logic vcount_q;

    // qualify core events with their enables
    always_comb begin
        flags_set = 8'h00;
        flags_set[NNSF_B_SETTING_ERR] = core_events.setting_change_err;
        flags_set[NNSF_B_WRITE_ERR] = core_events.port_write_err;
        flags_set[NNSF_B_PROC_ERR] = core_events.port_write_proc_err;
        flags_set[NNSF_B_PORT_CHG] = core_events.port_change
            | (core_events.port_fall & env_q[NNSF_E_FALL_ALL])
            | (core_events.port_rise & env_q[NNSF_E_RISE_ALL]);
        flags_set[NNSF_B_BCAST] = core_events.broadcast_rx & env_q[NNSF_E_BCAST];
        flags_set[NNSF_B_OVERFLOW] = core_events.rel_time_overflow
            & env_q[NNSF_E_OVERFLOW];
        flags_set[NNSF_B_INFO_LOSS] = core_events.change_info_loss
            & env_q[NNSF_E_INFO_LOSS];
        flags_set[NNSF_B_TIMEOUT] = core_events.comm_timeout & env_q[NNSF_E_TIMEOUT];
    end

    // clear sources: operation codes and write-one-to-clear
    always_comb begin
        flags_clr = 8'h00;
        if (status_w1c_lo) begin
            flags_clr = avs_writedata[7:0];
        end
        if (cmd_hit) begin
            case (opcode)
                NNSF_OP_CLR_SETTING: flags_clr[NNSF_B_SETTING_ERR] = 1'b1;
                NNSF_OP_CLR_WRITE: flags_clr[NNSF_B_WRITE_ERR] = 1'b1;
                NNSF_OP_CLR_PROC: flags_clr[NNSF_B_PROC_ERR] = 1'b1;
                NNSF_OP_CLR_BCAST: flags_clr[NNSF_B_BCAST] = 1'b1;
                NNSF_OP_CLR_OVERFLOW: flags_clr[NNSF_B_OVERFLOW] = 1'b1;
                NNSF_OP_CLR_INFO_LOSS: flags_clr[NNSF_B_INFO_LOSS] = 1'b1;
                NNSF_OP_CLR_TIMEOUT: flags_clr[NNSF_B_TIMEOUT] = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= NNSF_FLAGS_RST;
        end else begin
            flags_q <= (flags_q & ~flags_clr) | flags_set;
        end
    end

    // virtual count error, sticky, cleared only by write-one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vcount_q <= 1'b0;
        end else if (core_events.virtual_count_err) begin
            vcount_q <= 1'b1;
        end else if (status_w1c_hi && avs_writedata[NNSF_B_VCOUNT_ERR]) begin
            vcount_q <= 1'b0;
        end
    end

    // ****************************************
    // connection and break monitoring
    // ****************************************

    logic conn_q;
    logic brk_q;

    // connection follows connect and disconnect codes only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conn_q <= 1'b0;
        end else if (cmd_hit && opcode == NNSF_OP_CONNECT) begin
            conn_q <= 1'b1;
        end else if (cmd_hit && opcode == NNSF_OP_DISCONNECT) begin
            conn_q <= 1'b0;
        end
    end

    // break monitoring; the enable code wins over an answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            brk_q <= 1'b0;
        end else if (cmd_hit && opcode == NNSF_OP_BREAK_EN) begin
            brk_q <= 1'b1;
        end else if (break_request_answered) begin
            brk_q <= 1'b0;
        end
    end

    assign network_connected = conn_q;
    assign break_monitoring = brk_q;

    // ****************************************
    // status word and read path
    // ****************************************

    // assemble the live and latched bits
    always_comb begin
        status_word = 16'h0000;
        status_word[7:0] = flags_q;
        status_word[NNSF_B_CONNECTED] = conn_q;
        status_word[NNSF_B_BREAK_MON] = brk_q;
        status_word[NNSF_B_WATCHDOG] = watchdog_pin_low;
        status_word[NNSF_B_WRITE_BUSY] = port_write_in_progress;
        status_word[NNSF_B_VCOUNT_ERR] = vcount_q;
    end

    // read mux; unmapped and command offsets read zero
    always_comb begin
        rd_value = '0;
        case (avs_address)
            NNSF_OFS_STATUS: rd_value[15:0] = status_word;
            NNSF_OFS_ENV: rd_value[5:0] = env_q;
            NNSF_OFS_MASK: begin
                rd_value[7:0] = mask_q[7:0];
                rd_value[NNSF_B_VCOUNT_ERR] = mask_q[8];
            end
            default: rd_value = '0;
        endcase
    end

    // read data captured when the answer cycle begins, no side effect
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && bus_q == NNSF_BUS_IDLE) begin
            avs_readdata <= rd_value;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************

    logic irq_q;

    // level output; virtual count flag never reaches it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & mask_q[7:0]);
        end
    end

    assign irq = irq_q;

endmodule

// [rtl/nnsf_pkg.sv]
// constants and carrier types of the network node status flag block
package nnsf_pkg;

    // ****************************************
    // bus geometry and register map
    // ****************************************
    localparam int unsigned NNSF_ADDR_W = 4;
    localparam int unsigned NNSF_DATA_W = 32;
    localparam logic [3:0] NNSF_OFS_STATUS = 4'h0;
    localparam logic [3:0] NNSF_OFS_CMD = 4'h4;
    localparam logic [3:0] NNSF_OFS_ENV = 4'h8;
    localparam logic [3:0] NNSF_OFS_MASK = 4'hc;

    // ****************************************
    // status word bit positions
    // ****************************************
    localparam int unsigned NNSF_B_SETTING_ERR = 0;
    localparam int unsigned NNSF_B_WRITE_ERR = 1;
    localparam int unsigned NNSF_B_PROC_ERR = 2;
    localparam int unsigned NNSF_B_PORT_CHG = 3;
    localparam int unsigned NNSF_B_BCAST = 4;
    localparam int unsigned NNSF_B_OVERFLOW = 5;
    localparam int unsigned NNSF_B_INFO_LOSS = 6;
    localparam int unsigned NNSF_B_TIMEOUT = 7;
    localparam int unsigned NNSF_B_CONNECTED = 8;
    localparam int unsigned NNSF_B_BREAK_MON = 9;
    localparam int unsigned NNSF_B_WATCHDOG = 10;
    localparam int unsigned NNSF_B_WRITE_BUSY = 11;
    localparam int unsigned NNSF_B_VCOUNT_ERR = 12;

    // ****************************************
    // environment enable bit positions
    // ****************************************
    localparam int unsigned NNSF_E_FALL_ALL = 0;
    localparam int unsigned NNSF_E_RISE_ALL = 1;
    localparam int unsigned NNSF_E_BCAST = 2;
    localparam int unsigned NNSF_E_OVERFLOW = 3;
    localparam int unsigned NNSF_E_INFO_LOSS = 4;
    localparam int unsigned NNSF_E_TIMEOUT = 5;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] NNSF_FLAGS_RST = 8'h00;
    localparam logic [5:0] NNSF_ENV_RST = 6'h00;
    localparam logic [8:0] NNSF_MASK_RST = 9'h000;

    // ****************************************
    // operation codes
    // ****************************************
    localparam logic [7:0] NNSF_OP_CONNECT = 8'h10;
    localparam logic [7:0] NNSF_OP_DISCONNECT = 8'h11;
    localparam logic [7:0] NNSF_OP_BREAK_EN = 8'h12;
    localparam logic [7:0] NNSF_OP_CLR_SETTING = 8'h20;
    localparam logic [7:0] NNSF_OP_CLR_WRITE = 8'h21;
    localparam logic [7:0] NNSF_OP_CLR_PROC = 8'h22;
    localparam logic [7:0] NNSF_OP_CLR_BCAST = 8'h23;
    localparam logic [7:0] NNSF_OP_CLR_OVERFLOW = 8'h24;
    localparam logic [7:0] NNSF_OP_CLR_INFO_LOSS = 8'h25;
    localparam logic [7:0] NNSF_OP_CLR_TIMEOUT = 8'h26;

    // one-cycle event pulses from the device core
    typedef struct packed {
        logic setting_change_err;
        logic port_write_err;
        logic port_write_proc_err;
        logic port_change;
        logic port_fall;
        logic port_rise;
        logic broadcast_rx;
        logic rel_time_overflow;
        logic change_info_loss;
        logic comm_timeout;
        logic virtual_count_err;
    } nnsf_events_t;

    // bus slave handshake states
    typedef enum logic [1:0] {
        NNSF_BUS_IDLE = 2'b01,
        NNSF_BUS_ACK = 2'b10
    } nnsf_bus_state_t;

endpackage

// [bench/nnsf_status_sva.sv]
// port assertions of the status flag block
`timescale 1ns/10ps
module nnsf_status_sva
    import nnsf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [NNSF_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [NNSF_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [NNSF_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire nnsf_events_t core_events,
    input wire logic break_request_answered,
    input wire logic watchdog_pin_low,
    input wire logic port_write_in_progress,
    input wire logic network_connected,
    input wire logic break_monitoring,
    input wire logic irq
);
    // ****************************************
    // helpers
    // ****************************************
    logic wr_ok;
    logic ev_any;
    logic [3:0] live;
    assign wr_ok = avs_write && !avs_waitrequest;
    assign ev_any = |core_events[10:1];
    assign live = {port_write_in_progress, watchdog_pin_low, break_monitoring, network_connected};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // accepted command write
    sequence s_cmd(logic [7:0] op);
        wr_ok && avs_address == NNSF_OFS_CMD && avs_byteenable[0] && avs_writedata[7:0] == op;
    endsequence
    // ****************************************
    // properties
    // ****************************************
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    ack_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    top_zero_a: assert property (avs_readdata[31:13] == 19'h00000)
        else $error("upper status bits not zero");
    irq_rise_a: assert property ($rose(irq) |-> $past(ev_any || wr_ok, 2))
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_ok, 2))
        else $error("irq fell without write");
    conn_set_a: assert property (s_cmd(NNSF_OP_CONNECT) |=> network_connected)
        else $error("connect not taken");
    conn_clr_a: assert property (s_cmd(NNSF_OP_DISCONNECT) |=> !network_connected)
        else $error("disconnect not taken");
    conn_hold_a: assert property (!wr_ok |=> $stable(network_connected))
        else $error("connection changed without command");
    brk_set_a: assert property (s_cmd(NNSF_OP_BREAK_EN) |=> break_monitoring)
        else $error("break enable not taken");
    brk_clr_a: assert property (break_request_answered && !wr_ok |=> !break_monitoring)
        else $error("break monitoring not cleared");
    brk_rise_a: assert property ($rose(break_monitoring) |-> $past(wr_ok))
        else $error("break monitoring rose without command");
    live_bits_a: assert property (avs_read && !avs_waitrequest
        && avs_address == NNSF_OFS_STATUS |-> avs_readdata[11:8] == $past(live))
        else $error("live status bits wrong");
    rd_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without read");
endmodule
bind nnsf_status nnsf_status_sva i_sva (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_events(core_events), .break_request_answered(break_request_answered),
    .watchdog_pin_low(watchdog_pin_low), .port_write_in_progress(port_write_in_progress),
    .network_connected(network_connected), .break_monitoring(break_monitoring), .irq(irq));

// [bench/nnsf_host_model.sv]
// local cpu model: avalon master of the status block
`timescale 1ns/10ps
module nnsf_host_model
    import nnsf_pkg::*;
(
    input wire logic clock,
    output logic [NNSF_ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [NNSF_DATA_W-1:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [NNSF_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    // one bus cycle, held until waitrequest low; opcodes sent here
    task automatic xfer(input logic rw, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_read <= !rw;
        avs_write <= rw;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d; // released data does not keep last value
        if (n == 20) begin
            tb_top.mismatches++;
            tb_top.results();
        end
    endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench of the status flag block
`timescale 1ns/10ps
module tb_top import nnsf_pkg::*; ;
    logic clock = 1'b0;
    logic rst_n;
    logic [3:0] addr;
    logic rd_s, wr_s;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic waitreq, brk_ans, wd_low, wip, conn, brk, irq;
    nnsf_events_t core_events;
    int mismatches = 0;
    int n_checks = 0;
    int ev_idx[7] = '{10, 9, 8, 4, 3, 2, 1};
    int st_bit[7] = '{0, 1, 2, 4, 5, 6, 7};
    always #25 clock = ~clock;
    nnsf_status i_dut (.clock(clock), .rst_n(rst_n), .avs_address(addr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .core_events(core_events), .break_request_answered(brk_ans),
        .watchdog_pin_low(wd_low), .port_write_in_progress(wip), .network_connected(conn),
        .break_monitoring(brk), .irq(irq));
    nnsf_host_model i_host (.clock(clock), .avs_address(addr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic pulse(input nnsf_events_t ev);
        @(posedge clock);
        core_events <= ev;
        @(posedge clock);
        core_events <= 11'h000;
    endtask
    task automatic results();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        nnsf_events_t ev;
        rst_n = 1'b0;
        core_events = 11'h000;
        brk_ans = 1'b0;
        wd_low = 1'b0;
        wip = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd(NNSF_OFS_STATUS, 32'h0, "status reset");
        chk("irq reset", irq, 32'h0);
        pulse(11'h01e); // gated events with enables off
        rd(NNSF_OFS_STATUS, 32'h0, "gated events");
        pulse(11'h001);
        wr(NNSF_OFS_MASK, 32'h000010ff);
        wr(NNSF_OFS_ENV, 32'h0000003f);
        rd(NNSF_OFS_ENV, 32'h0000003f, "env readback");
        rd(NNSF_OFS_MASK, 32'h000010ff, "mask readback");
        rd(NNSF_OFS_STATUS, 32'h00001000, "vcount flag");
        chk("vcount irq", irq, 32'h0);
        wr(NNSF_OFS_STATUS, 32'h00001000);
        // each flag with a clear opcode: set, hold, irq, clear by opcode
        for (int i = 0; i < 7; i++) begin
            ev = 11'h000;
            ev[ev_idx[i]] = 1'b1;
            pulse(ev);
            rd(NNSF_OFS_STATUS, 32'h1 << st_bit[i], "flag set");
            rd(NNSF_OFS_STATUS, 32'h1 << st_bit[i], "flag held");
            chk("irq set", irq, 32'h1);
            wr(NNSF_OFS_CMD, 32'h20 + i);
            rd(NNSF_OFS_STATUS, 32'h0, "flag clear");
            chk("irq clear", irq, 32'h0);
        end
        // port change by direct event and both edge watches
        for (int i = 5; i < 8; i++) begin
            ev = 11'h000;
            ev[i] = 1'b1;
            pulse(ev);
            rd(NNSF_OFS_STATUS, 32'h00000008, "port change");
            wr(NNSF_OFS_STATUS, 32'h00000008);
        end
        // masked flag keeps irq low until unmasked
        wr(NNSF_OFS_MASK, 32'h0);
        pulse(11'h400);
        rd(NNSF_OFS_STATUS, 32'h00000001, "masked flag");
        chk("masked irq", irq, 32'h0);
        wr(NNSF_OFS_MASK, 32'h00000001);
        rd(NNSF_OFS_CMD, 32'h0, "cmd reads zero");
        chk("unmasked irq", irq, 32'h1);
        wr(NNSF_OFS_CMD, 32'h20);
        // connection and break monitoring
        wr(NNSF_OFS_CMD, 32'h10);
        rd(NNSF_OFS_STATUS, 32'h00000100, "connected");
        chk("connected out", conn, 32'h1);
        wr(NNSF_OFS_CMD, 32'h11);
        rd(NNSF_OFS_STATUS, 32'h0, "disconnected");
        chk("disconnected out", conn, 32'h0);
        wr(NNSF_OFS_CMD, 32'h12);
        rd(NNSF_OFS_STATUS, 32'h00000200, "break on");
        chk("break on out", brk, 32'h1);
        @(posedge clock);
        brk_ans <= 1'b1;
        @(posedge clock);
        brk_ans <= 1'b0;
        rd(NNSF_OFS_STATUS, 32'h0, "break answered");
        chk("break off out", brk, 32'h0);
        // live pins and unmapped place
        @(posedge clock);
        wd_low <= 1'b1;
        wip <= 1'b1;
        rd(NNSF_OFS_STATUS, 32'h00000c00, "live pins");
        rd(4'h2, 32'h0, "unmapped read");
        wr(4'h2, 32'hffffffff);
        rd(NNSF_OFS_STATUS, 32'h00000c00, "unmapped write");
        results();
    end
endmodule
